/* File: logic/fcg_defs.svh */
// Register offsets, field positions, reset values and constants of the CRC
`ifndef FCG_DEFS_SVH
`define FCG_DEFS_SVH

// Register offsets on the special function register space
`define FCG_ADDR_SAH    16'h5050
`define FCG_ADDR_EAH    16'h5051
`define FCG_ADDR_SAM    16'h5052
`define FCG_ADDR_EAM    16'h5053
`define FCG_ADDR_SAL    16'h5054
`define FCG_ADDR_EAL    16'h5055
`define FCG_ADDR_CTRL   16'h5056
`define FCG_ADDR_DIN    16'h5057
`define FCG_ADDR_RSH    16'h5058
`define FCG_ADDR_RSL    16'h5059

// Control register fields
`define FCG_CTL_RUN     0
`define FCG_CTL_CSEL_LO 1
`define FCG_CTL_CSEL_HI 3
`define FCG_CTL_SUM     5
`define FCG_CTL_CLR     6
`define FCG_CTL_USER    7
`define FCG_CSEL_SYS    2

// Reset values and engine constants
`define FCG_CRC_POLY    16'h8c81
`define FCG_RESULT_RST  16'h0000
`define FCG_RDATA_NONE  8'h00
`define FCG_FIFO_DEPTH  2

`endif

/* File: logic/fcg_pkg.sv */
// Types shared by the flash CRC and checksum generator
package fcg_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_fetch,
    st_drain
  } fcg_state_t;

endpackage

/* File: logic/fcg_fifo.sv */
// Small first-in first-out buffer in the data path of the signature engine
`timescale 1ns/10ps
`include "fcg_defs.svh"

module fcg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FCG_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // Fill side
  input  wire logic                       in_valid_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            in_ready_o,
  // Drain side
  output logic                            out_valid_o,
  output logic [WIDTH-1:0]                out_data_o,
  input  wire logic                       out_ready_i,
  // Fill level
  output logic [$clog2(DEPTH):0]          level_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fcg_fifo depth must be a power of two of at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fcg_fifo_st_t;

  fcg_fifo_st_t s;
  fcg_fifo_st_t next_s;
  logic         push;
  logic         pop;

  assign in_ready_o  = (s.count != (AW+1)'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o  = s.mem[s.rptr];
  assign level_o     = s.count;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wptr] = in_data_i;
      next_s.wptr        = s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = s.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // fcg_fifo

/* File: logic/fcg_flash_crc.sv */
// Flash CRC and checksum signature generator with auto and user modes
`timescale 1ns/10ps
`include "fcg_defs.svh"

module fcg_flash_crc #(
  parameter int FIFO_DEPTH = `FCG_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Special function register access
  input  wire logic [15:0] sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  // Internal RC oscillator, asynchronous to clk_i
  input  wire logic        rc_clk_i,
  // Flash read port
  output logic             flash_req_o,
  output logic      [23:0] flash_addr_o,
  input  wire logic        flash_ack_i,
  input  wire logic [7:0]  flash_rdata_i,
  // CPU control
  output logic             cpu_hold_o,
  output logic             irq_block_o
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fcg_flash_crc needs a buffer of at least two entries");
  end

  typedef struct packed {
    logic                rc_meta;
    logic                rc_sync;
    logic                rc_prev;
    logic [2:0]          div_cnt;
    logic [23:0]         sa;
    logic [23:0]         ea;
    logic                user;
    logic                sum;
    logic [2:0]          csel;
    logic                run;
    logic [15:0]         result;
    logic [23:0]         faddr;
    logic                req;
    fcg_pkg::fcg_state_t state;
    logic [7:0]          rdata;
    logic                hold;
  } fcg_st_t;

  fcg_st_t          s;
  fcg_st_t          next_s;
  logic             rc_edge;
  logic             ce;
  logic             wr_ctrl;
  logic             wr_din;
  logic             auto_push;
  logic             user_push;
  logic             start;
  logic             fifo_in_valid;
  logic [7:0]       fifo_in_data;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [7:0]       fifo_out_data;
  logic             pop;
  logic [LW-1:0]    level;
  logic [LW-1:0]    level_nx;
  logic [7:0]       rd_mux;

  // Fold one byte into a CRC, most significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0]  data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? `FCG_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Last count of the RC divider for each divide ratio
  function automatic logic [2:0] div_lim(input logic [1:0] sel);
    logic [2:0] lim;
    unique case (sel)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      2'h3: lim = 3'h7;
    endcase
    return lim;
  endfunction

  assign sfr_rdata_o  = s.rdata;
  assign flash_req_o  = s.req;
  assign flash_addr_o = s.faddr;
  assign cpu_hold_o   = s.hold;
  assign irq_block_o  = s.run;

  // Engine rate: rising RC edges divided, or every system clock
  assign rc_edge = s.rc_sync & ~s.rc_prev;
  assign ce      = s.csel[`FCG_CSEL_SYS] |
                   (rc_edge & (s.div_cnt == div_lim(s.csel[1:0])));

  assign wr_ctrl   = sfr_wr_i && (sfr_addr_i == `FCG_ADDR_CTRL);
  assign wr_din    = sfr_wr_i && (sfr_addr_i == `FCG_ADDR_DIN);
  assign auto_push = (s.state == fcg_pkg::st_fetch) && s.req && flash_ack_i;
  assign user_push = wr_din && s.user;
  assign start     = wr_ctrl && !s.run && (s.state == fcg_pkg::st_idle) &&
                     !sfr_wdata_i[`FCG_CTL_USER] &&
                     sfr_wdata_i[`FCG_CTL_RUN];

  assign fifo_in_valid = auto_push | user_push;
  assign fifo_in_data  = auto_push ? flash_rdata_i : sfr_wdata_i;
  assign pop           = fifo_out_valid & ce;

  fcg_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (fifo_in_valid),
    .in_data_i   (fifo_in_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (ce),
    .level_o     (level)
  );

  // Register read decode
  always_comb begin
    unique case (sfr_addr_i)
      `FCG_ADDR_SAH:  rd_mux = s.sa[23:16];
      `FCG_ADDR_SAM:  rd_mux = s.sa[15:8];
      `FCG_ADDR_SAL:  rd_mux = {s.sa[7:4], 4'h0};
      `FCG_ADDR_EAH:  rd_mux = s.ea[23:16];
      `FCG_ADDR_EAM:  rd_mux = s.ea[15:8];
      `FCG_ADDR_EAL:  rd_mux = s.ea[7:0];
      `FCG_ADDR_CTRL: rd_mux = {s.user, 1'b0, s.sum, 1'b0, s.csel, s.run};
      `FCG_ADDR_RSH:  rd_mux = s.result[15:8];
      `FCG_ADDR_RSL:  rd_mux = s.result[7:0];
      default:        rd_mux = `FCG_RDATA_NONE;
    endcase
  end

  always_comb begin
    next_s         = s;
    level_nx       = level;
    // Two-stage synchroniser, then edge history
    next_s.rc_meta = rc_clk_i;
    next_s.rc_sync = s.rc_meta;
    next_s.rc_prev = s.rc_sync;
    if (rc_edge) begin
      if (s.div_cnt >= div_lim(s.csel[1:0])) begin
        next_s.div_cnt = 3'h0;
      end else begin
        next_s.div_cnt = s.div_cnt + 1'b1;
      end
    end

    if (sfr_rd_i) begin
      next_s.rdata = rd_mux;
    end

    // Address registers are frozen while a run walks them
    if (sfr_wr_i && !s.run) begin
      unique case (sfr_addr_i)
        `FCG_ADDR_SAH: next_s.sa[23:16] = sfr_wdata_i;
        `FCG_ADDR_SAM: next_s.sa[15:8]  = sfr_wdata_i;
        `FCG_ADDR_SAL: next_s.sa[7:0]   = {sfr_wdata_i[7:4], 4'h0};
        `FCG_ADDR_EAH: next_s.ea[23:16] = sfr_wdata_i;
        `FCG_ADDR_EAM: next_s.ea[15:8]  = sfr_wdata_i;
        `FCG_ADDR_EAL: next_s.ea[7:0]   = sfr_wdata_i;
        default: ;
      endcase
    end

    // Signature engine
    if (pop) begin
      if (s.sum) begin
        next_s.result = s.result + {8'h00, fifo_out_data};
      end else begin
        next_s.result = crc_byte(s.result, fifo_out_data);
      end
    end

    if (wr_ctrl && !s.run) begin
      next_s.user = sfr_wdata_i[`FCG_CTL_USER];
      next_s.sum  = sfr_wdata_i[`FCG_CTL_SUM];
      next_s.csel = sfr_wdata_i[`FCG_CTL_CSEL_HI:`FCG_CTL_CSEL_LO];
      if (sfr_wdata_i[`FCG_CTL_CLR]) begin
        next_s.result = `FCG_RESULT_RST;
      end
    end

    unique case (s.state)
      fcg_pkg::st_idle: begin
        if (start) begin
          next_s.run    = 1'b1;
          next_s.result = `FCG_RESULT_RST;
          next_s.faddr  = {s.sa[23:4], 4'h0};
          next_s.state  = fcg_pkg::st_fetch;
        end
      end
      fcg_pkg::st_fetch: begin
        if (s.req && flash_ack_i) begin
          next_s.req = 1'b0;
          if (s.faddr >= s.ea) begin
            next_s.state = fcg_pkg::st_drain;
          end else begin
            next_s.faddr = s.faddr + 1'b1;
          end
        end else if (!s.req && fifo_in_ready) begin
          next_s.req = 1'b1;
        end
      end
      fcg_pkg::st_drain: begin
        if (!fifo_out_valid) begin
          next_s.run   = 1'b0;
          next_s.state = fcg_pkg::st_idle;
        end
      end
    endcase

    if (fifo_in_valid && fifo_in_ready && !pop) begin
      level_nx = level + 1'b1;
    end else if (pop && !(fifo_in_valid && fifo_in_ready)) begin
      level_nx = level - 1'b1;
    end
    // Hold the CPU for a run, or while user bytes would find no room
    next_s.hold = next_s.run ||
                  (next_s.user && (level_nx == LW'(FIFO_DEPTH)));
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_low_nibble;
    sfr_rd_i && (sfr_addr_i == `FCG_ADDR_SAL) |=> sfr_rdata_o[3:0] == 4'h0;
  endproperty
  a_low_nibble: assert property (p_low_nibble)
    else $error("start low byte shows nonzero low nibble");

  property p_start_holds;
    start |=> cpu_hold_o && irq_block_o && flash_addr_o[3:0] == 4'h0;
  endproperty
  a_start_holds: assert property (p_start_holds)
    else $error("auto start did not hold the CPU");

  property p_block_means_hold;
    irq_block_o |-> cpu_hold_o;
  endproperty
  a_block_means_hold: assert property (p_block_means_hold)
    else $error("interrupts blocked without CPU hold");

  property p_user_no_run;
    wr_ctrl && sfr_wdata_i[`FCG_CTL_USER] && !s.run |=> !irq_block_o;
  endproperty
  a_user_no_run: assert property (p_user_no_run)
    else $error("run started in user mode");

  property p_clear;
    wr_ctrl && sfr_wdata_i[`FCG_CTL_CLR] && !s.run && !start
      |=> s.result == `FCG_RESULT_RST;
  endproperty
  a_clear: assert property (p_clear)
    else $error("result not cleared");

  property p_user_crc;
    user_push && !fifo_out_valid && s.csel[`FCG_CSEL_SYS] && !s.sum
      ##1 !wr_ctrl
      |-> ##1 s.result == crc_byte($past(s.result, 2),
                                   $past(fifo_in_data, 2));
  endproperty
  a_user_crc: assert property (p_user_crc)
    else $error("user CRC byte folded wrongly");

  property p_user_sum;
    user_push && !fifo_out_valid && s.csel[`FCG_CSEL_SYS] && s.sum
      ##1 !wr_ctrl
      |-> ##1 s.result == $past(s.result, 2) +
                          {8'h00, $past(fifo_in_data, 2)};
  endproperty
  a_user_sum: assert property (p_user_sum)
    else $error("user checksum byte added wrongly");

  property p_auto_din_ignored;
    wr_din && !s.user && !s.run && !fifo_out_valid |=> $stable(s.result);
  endproperty
  a_auto_din_ignored: assert property (p_auto_din_ignored)
    else $error("data-in write changed result in auto mode");

  property p_range;
    flash_req_o |-> flash_addr_o <= s.ea || flash_addr_o[3:0] == 4'h0;
  endproperty
  a_range: assert property (p_range)
    else $error("flash fetch beyond end address");

  property p_done;
    $fell(irq_block_o) |-> !fifo_out_valid && !flash_req_o && !cpu_hold_o;
  endproperty
  a_done: assert property (p_done)
    else $error("run ended with bytes left");

  property p_rate;
    ce |-> s.csel[`FCG_CSEL_SYS] || $past(s.rc_sync) == 1'b0;
  endproperty
  a_rate: assert property (p_rate)
    else $error("engine stepped without a clock source edge");

  property p_result_high;
    sfr_rd_i && (sfr_addr_i == `FCG_ADDR_RSH)
      |=> sfr_rdata_o == $past(s.result[15:8]);
  endproperty
  a_result_high: assert property (p_result_high)
    else $error("result high byte read wrongly");

  c_auto_done: cover property ($fell(irq_block_o));
  c_user_crc: cover property (pop && s.user && !s.sum);
  c_auto_sum: cover property (pop && s.run && s.sum);
  c_user_hold: cover property (cpu_hold_o && !irq_block_o);

endmodule // fcg_flash_crc

/* File: testbench/fcg_flash_model.sv */
// Behavioural program flash answering the generator's read requests
`timescale 1ns/10ps

module fcg_flash_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Read port
  input  wire logic        req_i,
  input  wire logic [23:0] addr_i,
  output logic             ack_o,
  output logic      [7:0]  rdata_o
);
  logic [1:0] wait_cnt;
  logic       slow;

  // Answers alternate between prompt and three cycles late
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      rdata_o <= 8'h00;
    end else if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      // Data outside an answer is not held
      rdata_o <= ~rdata_o;
    end else if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      ack_o <= 1'b1;
      rdata_o <= addr_i[7:0] ^ addr_i[15:8] ^ 8'h3c;
      wait_cnt <= 2'h0;
      slow <= ~slow;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // fcg_flash_model

/* File: testbench/fcg_flash_crc_tb.sv */
// Self-checking testbench of the flash CRC and checksum generator
`timescale 1ns/10ps
`include "fcg_defs.svh"

module fcg_flash_crc_tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rc_clk_i = 1'b0;
  logic [15:0] sfr_addr_i = 16'h0000;
  logic        sfr_wr_i = 1'b0;
  logic        sfr_rd_i = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic [7:0]  sfr_rdata_o;
  logic        flash_req_o;
  logic [23:0] flash_addr_o;
  logic        flash_ack_i;
  logic [7:0]  flash_rdata_i;
  logic        cpu_hold_o;
  logic        irq_block_o;
  int          failures = 0;
  int          cmp_count = 0;
  logic [23:0] seen_q[$];

  always #12.5 clk_i = ~clk_i;
  // Internal RC near 4 MHz, phase unrelated to clk_i
  always #127.3 rc_clk_i = ~rc_clk_i;

  fcg_flash_crc fcg_flash_crc_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .rc_clk_i(rc_clk_i),
    .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o),
    .flash_ack_i(flash_ack_i), .flash_rdata_i(flash_rdata_i),
    .cpu_hold_o(cpu_hold_o), .irq_block_o(irq_block_o));

  fcg_flash_model fcg_flash_model_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(flash_req_o),
    .addr_i(flash_addr_o), .ack_o(flash_ack_i), .rdata_o(flash_rdata_i));

  always @(posedge clk_i) begin
    if (flash_req_o === 1'b1 && flash_ack_i === 1'b1) begin
      seen_q.push_back(flash_addr_o);
    end
  end

  task automatic sfr_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask

  task automatic sfr_read(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    @(negedge clk_i);
    d = sfr_rdata_o;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    sfr_read(a, d);
    chk8($sformatf("reg %h", a), e, d);
  endtask

  task automatic chk_result(input logic [15:0] e);
    chk_reg(`FCG_ADDR_RSH, e[15:8]);
    chk_reg(`FCG_ADDR_RSL, e[7:0]);
  endtask

  function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] d,
                                       logic sum);
    if (sum) begin
      return c + {8'h00, d};
    end
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `FCG_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  task automatic t_regs();
    logic [15:0] a[6];
    logic [7:0]  w[6];
    logic [7:0]  e[6];
    a = '{`FCG_ADDR_SAH, `FCG_ADDR_EAH, `FCG_ADDR_SAM, `FCG_ADDR_EAM,
          `FCG_ADDR_SAL, `FCG_ADDR_EAL};
    w = '{8'h12, 8'h56, 8'h34, 8'h78, 8'hff, 8'h9a};
    e = '{8'h12, 8'h56, 8'h34, 8'h78, 8'hf0, 8'h9a};
    for (int i = 0; i < 6; i++) begin
      sfr_write(a[i], w[i]);
    end
    for (int i = 0; i < 6; i++) begin
      chk_reg(a[i], e[i]);
    end
    sfr_write(16'h505a, 8'h77);
    chk_reg(16'h505a, 8'h00);
    sfr_write(`FCG_ADDR_CTRL, 8'hee);
    chk_reg(`FCG_ADDR_CTRL, 8'hae);
    $display("test regs done");
  endtask

  task automatic t_user(input logic [7:0] ctl);
    logic [7:0]  b[4];
    logic [15:0] exp;
    logic        held;
    b = '{8'h00, 8'hff, 8'h31, 8'h80};
    exp = 16'h0000;
    held = 1'b0;
    sfr_write(`FCG_ADDR_CTRL, ctl);
    for (int i = 0; i < 4; i++) begin
      held = held | (cpu_hold_o === 1'b1);
      for (int k = 0; k < 300 && cpu_hold_o !== 1'b0; k++) begin
        @(negedge clk_i);
      end
      sfr_write(`FCG_ADDR_DIN, b[i]);
      exp = fold(exp, b[i], ctl[5]);
    end
    // Slow engine clocks need time to drain the buffer
    repeat (ctl[3] ? 4 : 250) @(negedge clk_i);
    chk_result(exp);
    chk8("user hold", {7'h00, ~ctl[3]}, {7'h00, held});
    sfr_write(`FCG_ADDR_CTRL, ctl);
    chk_result(16'h0000);
    $display("test user ctl=%h done", ctl);
  endtask

  task automatic t_auto(input logic [7:0] ctl, input logic [23:0] sa,
                        input logic [23:0] ea);
    logic [15:0] exp;
    logic [23:0] st;
    logic [23:0] ad;
    int          n;
    st = {sa[23:4], 4'h0};
    n = int'(ea - st) + 1;
    exp = 16'h0000;
    sfr_write(`FCG_ADDR_SAH, sa[23:16]);
    sfr_write(`FCG_ADDR_SAM, sa[15:8]);
    sfr_write(`FCG_ADDR_SAL, sa[7:0]);
    sfr_write(`FCG_ADDR_EAH, ea[23:16]);
    sfr_write(`FCG_ADDR_EAM, ea[15:8]);
    sfr_write(`FCG_ADDR_EAL, ea[7:0]);
    sfr_write(`FCG_ADDR_CTRL, ctl);
    seen_q.delete();
    sfr_write(`FCG_ADDR_CTRL, ctl | 8'h01);
    chk8("hold", 8'h01, {7'h00, cpu_hold_o});
    chk8("irq block", 8'h01, {7'h00, irq_block_o});
    for (int k = 0; k < 4000 && cpu_hold_o !== 1'b0; k++) begin
      @(negedge clk_i);
    end
    chk8("irq block end", 8'h00, {7'h00, irq_block_o});
    repeat (3) @(negedge clk_i);
    chk8("byte count", 8'(n), 8'(seen_q.size()));
    for (int i = 0; i < n; i++) begin
      ad = st + 24'(i);
      exp = fold(exp, ad[7:0] ^ ad[15:8] ^ 8'h3c, ctl[5]);
      if (i < seen_q.size()) begin
        chk8("addr lo", ad[7:0], seen_q[i][7:0]);
        chk8("addr mid", ad[15:8], seen_q[i][15:8]);
        chk8("addr hi", ad[23:16], seen_q[i][23:16]);
      end
    end
    chk_result(exp);
    chk_reg(`FCG_ADDR_CTRL, ctl);
    sfr_write(`FCG_ADDR_DIN, 8'h55);
    repeat (4) @(negedge clk_i);
    chk_result(exp);
    $display("test auto ctl=%h done", ctl);
  endtask

  task automatic t_reset_mid();
    sfr_write(`FCG_ADDR_EAL, 8'h0f);
    sfr_write(`FCG_ADDR_CTRL, 8'h07);
    repeat (5) @(negedge clk_i);
    chk8("hold mid run", 8'h03, {6'h00, cpu_hold_o, irq_block_o});
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk8("outputs in reset", 8'h00,
         {5'h00, cpu_hold_o, irq_block_o, flash_req_o});
    chk8("rdata in reset", 8'h00, sfr_rdata_o);
    rst_b_i = 1'b1;
    chk_reg(`FCG_ADDR_CTRL, 8'h00);
    chk_result(16'h0000);
    chk_reg(`FCG_ADDR_EAL, 8'h00);
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    t_regs();
    t_user(8'hc8);
    t_user(8'he8);
    t_user(8'hc6);
    t_auto(8'h08, 24'h012345, 24'h012343);
    t_auto(8'h28, 24'h00ff08, 24'h00ff02);
    for (int c = 0; c < 4; c++) begin
      t_auto(8'(c << 1) | (c[0] ? 8'h20 : 8'h00), 24'h000200, 24'h000201);
    end
    t_reset_mid();
    summarize();
  end
endmodule // fcg_flash_crc_tb
